// ---- shared/mwdog_cfg.svh ----
`ifndef MWDOG_CFG_SVH
`define MWDOG_CFG_SVH

// ==========================================
// Register indexes (byte address = 4 * index)
`define MWD_IDX_FREQ     8'h51
`define MWD_IDX_CTRL     8'hD6
`define MWD_IDX_OFF      8'hD7
`define MWD_IDX_STATUS   8'hE0
`define MWD_IDX_MASK     8'hE1

// ==========================================
// Field positions and values
`define MWD_FREQ_MSB     6
`define MWD_TMO_MSB      15
`define MWD_CNT_LSB      16
`define MWD_ST_EXPIRE    0
`define MWD_ST_NACK      1
`define MWD_OFF_MAGIC    32'h0D15AB1E
`define MWD_OFF_ENABLE   32'h00000000

// ==========================================
// Reset values
`define MWD_FREQ_RST     7'h19
`define MWD_TMO_RST      16'h03E8
`define MWD_CNT_RST      16'h0000
`define MWD_OFF_RST      32'h0D15AB1E

// ==========================================
// Frequency limits and tick timing
`define MWD_FREQ_MIN     7'h05
`define MWD_FREQ_MAX     7'h64
`define MWD_TICK_US      17'h003E8

`endif

// ---- shared/mwdog_pkg.sv ----
package mwdog_pkg;

  typedef enum logic [1:0] {
    MWDOG_RESP_OKAY   = 2'h0,
    MWDOG_RESP_SLVERR = 2'h2,
    MWDOG_RESP_DECERR = 2'h3
  } mwdog_resp_type;

  typedef enum logic {
    MWDOG_BUS_IDLE   = 1'b0,
    MWDOG_BUS_ANSWER = 1'b1
  } mwdog_bus_type;

endpackage

// ---- design/mwdog_sync.sv ----
`timescale 1ns/1ps

module mwdog_sync (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ---- design/mwdog_tick.sv ----
`timescale 1ns/1ps
`include "mwdog_cfg.svh"

module mwdog_tick (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [6:0] freq_mhz,
  output logic            tick
);

  logic [16:0] div_cnt_reg;
  logic [16:0] div_cnt_next;
  logic        tick_reg;
  logic        tick_next;
  logic [16:0] divisor;

  // ==========================================
  // Free-running prescaler, one pulse per millisecond
  always_comb begin
    divisor = 17'(freq_mhz) * `MWD_TICK_US;
    tick_next = 1'b0;
    div_cnt_next = div_cnt_reg + 17'h00001;
    // A smaller setting written mid-count wraps at once, not after 2^17
    if (div_cnt_reg >= divisor - 17'h00001) begin
      div_cnt_next = 17'h00000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  AST_TICK_SPACING: assert property (
    @(posedge mclk) disable iff (reset) tick |=> !tick [*4])
    else $error("millisecond ticks too close together");

endmodule

// ---- design/mwdog_top.sv ----
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "mwdog_cfg.svh"

// Contract
// - Timeout counts one-millisecond ticks, spanning about 1 ms to 65 s.
// - Counter advances only in running power state, holds otherwise.
// - Timeout write needs exact 16-bit complement above it, else NACK.
// - Expiry resets the processing tile.
// - Software kicks periodically; each kick restarts countdown from timeout.
// - Control upper half is read-only current count, reset zero.
// - Control lower half holds timeout ticks, read-write, reset 1000.
// - Expiry initiates a system reset.
// - Magic disable word resets the counter and stops counting.
// - Writing zero enables; disable register 32-bit RW, resets to magic.
// - Frequency field holds oscillator MHz, read-write, reset 25.
// - Frequency writes outside 5 to 100 are ignored and NACKed.
// - Tick derives from system clock using programmed frequency.
// - Expiry is a source of the system-level reset.
module mwdog_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        running_power_state,
  output logic             tile_reset_req,
  output logic             sys_reset_req,
  output logic             irq
);

  // ==========================================
  // Clock-domain entry and tick
  logic running_power_state_s;
  logic tick;
  logic [6:0] freq_reg;

  mwdog_sync u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (running_power_state),
    .sync_out (running_power_state_s)
  );

  mwdog_tick u_tick (
    .mclk     (mclk),
    .reset    (reset),
    .freq_mhz (freq_reg),
    .tick     (tick)
  );

  // ==========================================
  // Register state
  mwdog_pkg::mwdog_bus_type state_reg;
  mwdog_pkg::mwdog_bus_type state_next;
  mwdog_pkg::mwdog_resp_type resp_reg;
  mwdog_pkg::mwdog_resp_type resp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [6:0]  freq_next;
  logic [15:0] timeout_reg;
  logic [15:0] timeout_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [31:0] off_reg;
  logic [31:0] off_next;
  logic        expire_reg;
  logic        expire_next;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic [1:0]  mask_reg;
  logic [1:0]  mask_next;

  logic [7:0]  idx;
  logic        enabled;
  logic        commit;
  logic        wr_ok;
  logic        nack_evt;
  logic        run;
  logic [1:0]  events;

  function automatic logic cmpl_ok(input logic [31:0] d);
    cmpl_ok = (d[31:16] == ~d[15:0]);
  endfunction

  function automatic logic freq_ok(input logic [6:0] f, input logic [31:0] d);
    freq_ok = (d[31:7] == 25'h0000000) && (f >= `MWD_FREQ_MIN) && (f <= `MWD_FREQ_MAX);
  endfunction

  assign idx      = avs_address[9:2];
  assign enabled  = (off_reg != `MWD_OFF_MAGIC);
  assign commit   = (state_reg == mwdog_pkg::MWDOG_BUS_ANSWER) && avs_write;
  assign wr_ok    = commit && (resp_reg == mwdog_pkg::MWDOG_RESP_OKAY);
  assign nack_evt = commit && (resp_reg == mwdog_pkg::MWDOG_RESP_SLVERR);
  assign run      = enabled && running_power_state_s && tick;

  // ==========================================
  // Avalon slave: request seen in IDLE, answered in ANSWER
  always_comb begin
    state_next = state_reg;
    resp_next = resp_reg;
    rdata_next = rdata_reg;
    case (state_reg)
      mwdog_pkg::MWDOG_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = mwdog_pkg::MWDOG_BUS_ANSWER;
          resp_next = mwdog_pkg::MWDOG_RESP_OKAY;
          rdata_next = 32'h00000000;
          case (idx)
            `MWD_IDX_FREQ: begin
              rdata_next = {25'h0000000, freq_reg};
              if (avs_write && !freq_ok(avs_writedata[6:0], avs_writedata)) begin
                resp_next = mwdog_pkg::MWDOG_RESP_SLVERR;
              end
            end
            `MWD_IDX_CTRL: begin
              rdata_next = {count_reg, timeout_reg};
              if (avs_write && !cmpl_ok(avs_writedata)) begin
                resp_next = mwdog_pkg::MWDOG_RESP_SLVERR;
              end
            end
            `MWD_IDX_OFF: begin
              rdata_next = off_reg;
            end
            `MWD_IDX_STATUS: begin
              rdata_next = {30'h00000000, status_reg};
            end
            `MWD_IDX_MASK: begin
              rdata_next = {30'h00000000, mask_reg};
            end
            default: begin
              resp_next = mwdog_pkg::MWDOG_RESP_DECERR;
            end
          endcase
        end
      end
      mwdog_pkg::MWDOG_BUS_ANSWER: begin
        state_next = mwdog_pkg::MWDOG_BUS_IDLE;
      end
      default: begin
        state_next = mwdog_pkg::MWDOG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= mwdog_pkg::MWDOG_BUS_IDLE;
      resp_reg <= mwdog_pkg::MWDOG_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      resp_reg <= resp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Wait state is combinational so a request is released on the answer edge
  assign avs_waitrequest = (avs_read || avs_write) && (state_reg != mwdog_pkg::MWDOG_BUS_ANSWER);
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;

  // ==========================================
  // Watchdog core
  always_comb begin
    freq_next = freq_reg;
    timeout_next = timeout_reg;
    count_next = count_reg;
    off_next = off_reg;
    expire_next = 1'b0;
    if (run) begin
      // Count of one reaches expiry on this tick; zero expires every tick
      if (count_reg <= 16'h0001) begin
        expire_next = 1'b1;
        count_next = timeout_reg;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
    // A write on the same edge as a tick wins: software intent is newer
    if (wr_ok) begin
      case (idx)
        `MWD_IDX_FREQ: begin
          freq_next = avs_writedata[`MWD_FREQ_MSB:0];
        end
        `MWD_IDX_CTRL: begin
          timeout_next = avs_writedata[`MWD_TMO_MSB:0];
          count_next = avs_writedata[`MWD_TMO_MSB:0];
          expire_next = 1'b0;
        end
        `MWD_IDX_OFF: begin
          off_next = avs_writedata;
          if (avs_writedata == `MWD_OFF_MAGIC) begin
            count_next = `MWD_CNT_RST;
            expire_next = 1'b0;
          end else if (!enabled) begin
            count_next = timeout_reg;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      freq_reg <= `MWD_FREQ_RST;
      timeout_reg <= `MWD_TMO_RST;
      count_reg <= `MWD_CNT_RST;
      off_reg <= `MWD_OFF_RST;
      expire_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      timeout_reg <= timeout_next;
      count_reg <= count_next;
      off_reg <= off_next;
      expire_reg <= expire_next;
    end
  end

  assign tile_reset_req = expire_reg;
  assign sys_reset_req = expire_reg;

  // ==========================================
  // Interrupt status and mask
  assign events = {nack_evt, expire_reg};

  always_comb begin
    status_next = status_reg;
    mask_next = mask_reg;
    if (wr_ok && (idx == `MWD_IDX_STATUS)) begin
      status_next = status_reg & ~avs_writedata[1:0];
    end
    if (wr_ok && (idx == `MWD_IDX_MASK)) begin
      mask_next = avs_writedata[1:0];
    end
    // New events set after the clear so none is lost
    status_next = status_next | events;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status_reg <= 2'h0;
      mask_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ==========================================
  // Checks
  AST_HOLD_ASLEEP: assert property (
    @(posedge mclk) disable iff (reset)
    (!running_power_state_s && !commit) |=> (count_reg == $past(count_reg)))
    else $error("count moved outside running power state");

  AST_COUNT_DOWN: assert property (
    @(posedge mclk) disable iff (reset)
    (run && (count_reg > 16'h0001) && !commit) |=> (count_reg == $past(count_reg) - 16'h0001))
    else $error("count did not step down by one on a tick");

  AST_CTRL_NACK: assert property (
    @(posedge mclk) disable iff (reset)
    ((state_reg == mwdog_pkg::MWDOG_BUS_IDLE) && avs_write && (idx == `MWD_IDX_CTRL)
      && !cmpl_ok(avs_writedata))
    |=> (avs_response == mwdog_pkg::MWDOG_RESP_SLVERR) && !avs_waitrequest)
    else $error("bad complement not refused");

  AST_KICK_LOADS: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_ok && (idx == `MWD_IDX_CTRL))
    |=> (count_reg == $past(avs_writedata[15:0])) && (timeout_reg == count_reg))
    else $error("kick did not reload countdown");

  AST_FREQ_RANGE: assert property (
    @(posedge mclk) disable iff (reset)
    (commit && (idx == `MWD_IDX_FREQ) && !freq_ok(avs_writedata[6:0], avs_writedata))
    |=> (freq_reg == $past(freq_reg)))
    else $error("out-of-range frequency stored");

  AST_MAGIC_STOPS: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_ok && (idx == `MWD_IDX_OFF) && (avs_writedata == `MWD_OFF_MAGIC))
    |=> (count_reg == 16'h0000) ##1 (count_reg == 16'h0000) && !tile_reset_req)
    else $error("magic word did not stop the watchdog");

  AST_EXPIRE_RESET: assert property (
    @(posedge mclk) disable iff (reset)
    (run && (count_reg == 16'h0001) && !commit)
    |=> tile_reset_req && sys_reset_req && (count_reg == timeout_reg) ##1 !tile_reset_req)
    else $error("expiry did not raise a one-cycle reset request");

  AST_READ_COUNT: assert property (
    @(posedge mclk) disable iff (reset)
    ((state_reg == mwdog_pkg::MWDOG_BUS_IDLE) && avs_read && (idx == `MWD_IDX_CTRL))
    |=> (avs_readdata == {$past(count_reg), $past(timeout_reg)}))
    else $error("control read did not show count and timeout");

endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "mwdog_cfg.svh"

module tb_top;
  typedef struct {
    logic        wr;
    logic [9:0]  addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic [1:0]  rsp;
  } mwdog_row_type;

  localparam logic [9:0] A_FREQ = {`MWD_IDX_FREQ, 2'h0};
  localparam logic [9:0] A_CTRL = {`MWD_IDX_CTRL, 2'h0};
  localparam logic [9:0] A_OFF  = {`MWD_IDX_OFF, 2'h0};
  localparam logic [9:0] A_STAT = {`MWD_IDX_STATUS, 2'h0};
  localparam logic [9:0] A_MASK = {`MWD_IDX_MASK, 2'h0};

  logic        mclk;
  logic        reset;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        running_power_state;
  logic        tile_reset_req;
  logic        sys_reset_req;
  logic        irq;
  int          miscompares;
  int          check_count;
  int          pulses;
  int          p0;
  int          c;
  mwdog_row_type rows [24];

  mwdog_top dut (
    .mclk                (mclk),
    .reset               (reset),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .avs_response        (avs_response),
    .running_power_state (running_power_state),
    .tile_reset_req      (tile_reset_req),
    .sys_reset_req       (sys_reset_req),
    .irq                 (irq)
  );

  // ==========================================
  // Helpers
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk({31'h0, avs_waitrequest}, 32'h0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [31:0] rd;
    logic [1:0]  rsp;
    bus(1'b1, a, d, rd, rsp);
    chk({30'h0, rsp}, {30'h0, r});
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] got;
    logic [1:0]  rsp;
    bus(1'b0, a, 32'h0, got, rsp);
    chk(got, e);
    chk({30'h0, rsp}, 32'h0);
  endtask

  task automatic wait_pulse(input int lim, output int n);
    n = 0;
    while (tile_reset_req !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // Both reset requests must come together, one count per cycle high
  always @(posedge mclk) begin
    if (tile_reset_req === 1'b1 || sys_reset_req === 1'b1) begin
      pulses++;
      chk({31'h0, sys_reset_req}, {31'h0, tile_reset_req});
    end
  end

  // ==========================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    // The tests take about 68,000 cycles; this leaves a quarter more as margin
    #420000;
    miscompares++;
    $display("mismatch at %0t: got %h expected %h", $time, 1'h0, 1'h1);
    finish_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] got;
    logic [1:0]  rsp;
    reset = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    running_power_state = 1'b1;
    miscompares = 0;
    check_count = 0;
    pulses = 0;
    rows = '{
      '{1'b0, A_FREQ, 32'h0, 32'h00000019, 2'h0}, '{1'b0, A_CTRL, 32'h0, 32'h000003E8, 2'h0},
      '{1'b0, A_OFF, 32'h0, 32'h0D15AB1E, 2'h0}, '{1'b0, A_STAT, 32'h0, 32'h00000000, 2'h0},
      '{1'b0, A_MASK, 32'h0, 32'h00000000, 2'h0}, '{1'b1, A_FREQ, 32'h00000004, 32'h0, 2'h2},
      '{1'b1, A_FREQ, 32'h00000065, 32'h0, 2'h2}, '{1'b1, A_FREQ, 32'h00000085, 32'h0, 2'h2},
      '{1'b0, A_FREQ, 32'h0, 32'h00000019, 2'h0}, '{1'b0, A_STAT, 32'h0, 32'h00000002, 2'h0},
      '{1'b1, A_STAT, 32'h00000002, 32'h0, 2'h0}, '{1'b0, A_STAT, 32'h0, 32'h00000000, 2'h0},
      '{1'b1, A_FREQ, 32'h00000064, 32'h0, 2'h0}, '{1'b0, A_FREQ, 32'h0, 32'h00000064, 2'h0},
      '{1'b1, A_FREQ, 32'h00000005, 32'h0, 2'h0}, '{1'b0, A_FREQ, 32'h0, 32'h00000005, 2'h0},
      '{1'b1, A_CTRL, 32'hFFFC0004, 32'h0, 2'h2}, '{1'b0, A_CTRL, 32'h0, 32'h000003E8, 2'h0},
      '{1'b1, A_CTRL, 32'hFFFC0003, 32'h0, 2'h0}, '{1'b0, A_CTRL, 32'h0, 32'h00030003, 2'h0},
      '{1'b1, A_OFF, 32'h00000000, 32'h0, 2'h0}, '{1'b0, A_OFF, 32'h0, 32'h00000000, 2'h0},
      '{1'b0, 10'h3F0, 32'h0, 32'h00000000, 2'h3}, '{1'b1, 10'h3F0, 32'h00000001, 32'h0, 2'h3}
    };
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].addr, rows[i].data, got, rsp);
      if (!rows[i].wr) chk(got, rows[i].exp);
      chk({30'h0, rsp}, {30'h0, rows[i].rsp});
    end
    $display("register table done");
    wr(A_FREQ, 32'h00000005, 2'h0);
    // Third tick of a 5000-cycle prescaler expires a timeout of 3
    wr(A_CTRL, 32'hFFFC0003, 2'h0);
    wait_pulse(16000, c);
    chk({31'h0, c >= 10000 && c <= 15010}, 32'h1);
    rd(A_STAT, 32'h00000003);
    chk({31'h0, irq}, 32'h0);
    // A write lands on the answer edge, so irq is looked at one edge later
    wr(A_MASK, 32'h00000001, 2'h0);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_STAT, 32'h00000003, 2'h0);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_STAT, 32'h00000000);
    $display("expiry and interrupt done");
    // Asleep: no counting, count held
    running_power_state <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(A_CTRL, 32'hFFFE0001, 2'h0);
    p0 = pulses;
    repeat (12000) @(posedge mclk);
    chk(pulses - p0, 32'h0);
    rd(A_CTRL, 32'h00010001);
    running_power_state <= 1'b1;
    wait_pulse(5020, c);
    chk({31'h0, tile_reset_req}, 32'h1);
    $display("power state done");
    // Kicks every 4000 cycles never let a 3-tick timeout run out
    repeat (2) @(posedge mclk);
    wr(A_CTRL, 32'hFFFC0003, 2'h0);
    p0 = pulses;
    for (int i = 0; i < 5; i++) begin
      repeat (4000) @(posedge mclk);
      wr(A_CTRL, 32'hFFFC0003, 2'h0);
    end
    chk(pulses - p0, 32'h0);
    $display("kick done");
    wr(A_OFF, `MWD_OFF_MAGIC, 2'h0);
    rd(A_CTRL, 32'h00000003);
    p0 = pulses;
    repeat (16000) @(posedge mclk);
    chk(pulses - p0, 32'h0);
    $display("disable done");
    // Second reset in mid-run restores the documented values
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(A_CTRL, 32'h000003E8);
    rd(A_OFF, 32'h0D15AB1E);
    rd(A_FREQ, 32'h00000019);
    $display("second reset done");
    finish_test();
  end
endmodule
